// ===== design/rfc_map.svh
// Offsets, field positions, reset values and access codes of the receiver front control bank.
`ifndef RFC_MAP_SVH
`define RFC_MAP_SVH

`define RFC_DATA_W       22
`define RFC_ADDR_W       10
`define RFC_NUM_REGS     11

`define RFC_OFS_CLKDIV   10'h000
`define RFC_OFS_SYNTH0   10'h001
`define RFC_OFS_CLAMP    10'h005
`define RFC_OFS_RSVD6    10'h006
`define RFC_OFS_RSVD7    10'h007
`define RFC_OFS_RSVD8    10'h008
`define RFC_OFS_RSVD9    10'h009
`define RFC_OFS_COARSE   10'h00a

`define RFC_RST_CLKDIV   1'h1
`define RFC_RST_SYNTH    22'h000000
`define RFC_RST_CLAMP    6'h23
`define RFC_RST_RSVD     8'h00
`define RFC_RST_RSVD9    2'h0
`define RFC_RST_COARSE   4'h0

`define RFC_BIT_CAL_B    3
`define RFC_BIT_CAL_A    2
`define RFC_BIT_PN       1
`define RFC_BIT_COARSE   0
`define RFC_BIT_CLAMP_B  1
`define RFC_BIT_CLAMP_A  0
`define RFC_TRIM_HI      5
`define RFC_TRIM_LO      2

`define RFC_SEL_LOW      2'h0
`define RFC_SEL_MID      2'h1
`define RFC_SEL_HIGH     2'h2

`endif

// ===== design/rfc_pkg.sv
// Types shared by the receiver front control bank.
package rfc_pkg;
  `include "rfc_map.svh"

  typedef struct packed {
    logic       clk_div_two;
    logic [3:0] gain_trim;
    logic       clamp_dis_b;
    logic       clamp_dis_a;
    logic       cal_now_b;
    logic       cal_now_a;
    logic       test_pattern_gen_on;
    logic       coarse_offset_fix_on;
  } rfc_ctrl_t;

  typedef struct packed {
    logic [3:0][`RFC_DATA_W-1:0] word;
  } rfc_synth_t;

  typedef enum logic [2:0] {
    RFC_CAL_IDLE = 3'h1,
    RFC_CAL_GO   = 3'h2,
    RFC_CAL_BUSY = 3'h4
  } rfc_cal_state_t;
endpackage

// ===== design/rfc_field_reg.sv
// One control register of the bank: stores the low bits of a committed data word.
`timescale 1ns/100ps
`include "rfc_map.svh"
module rfc_field_reg
  import rfc_pkg::*;
#(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic                  mclk_i,
  input  wire logic                  arst_n_i,
  input  wire logic                  we_i,
  input  wire logic [`RFC_DATA_W-1:0] wdata_i,
  output logic      [W-1:0]          q_o
);
  logic [W-1:0] val_d;
  logic [W-1:0] val_q;

  always_comb begin
    val_d = val_q;
    if (we_i) begin
      val_d = wdata_i[W-1:0];
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      val_q <= RST;
    end else begin
      val_q <= val_d;
    end
  end

  assign q_o = val_q;
endmodule // rfc_field_reg

// ===== design/rfc_cal_seq.sv
// Coarse offset calibration sequencer for one channel.
`timescale 1ns/100ps
module rfc_cal_seq
  import rfc_pkg::*;
(
  input  wire logic mclk_i,
  input  wire logic arst_n_i,
  input  wire logic req_i,
  input  wire logic enable_i,
  input  wire logic done_i,
  output logic      go_o,
  output logic      busy_o
);
  rfc_cal_state_t state_d;
  rfc_cal_state_t state_q;
  logic           pend_d;
  logic           pend_q;

  always_comb begin
    state_d = state_q;
    pend_d  = pend_q | req_i;
    case (state_q)
      RFC_CAL_IDLE: begin
        if (pend_d && enable_i) begin
          state_d = RFC_CAL_GO;
          pend_d  = 1'b0;
        end
      end
      RFC_CAL_GO: begin
        state_d = RFC_CAL_BUSY;
      end
      RFC_CAL_BUSY: begin
        if (done_i) begin
          state_d = RFC_CAL_IDLE;
        end
      end
      default: begin
        state_d = RFC_CAL_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= RFC_CAL_IDLE;
      pend_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      pend_q  <= pend_d;
    end
  end

  assign go_o   = (state_q == RFC_CAL_GO);
  assign busy_o = (state_q != RFC_CAL_IDLE);
endmodule // rfc_cal_seq

// ===== design/rfc_regs.sv
// Control register bank of the receiver front end, reached through the data word microport.
//
// Function
// - Clock divider bit resets to one, divide-by-two; zero bypasses the divider.
// - Four 22-bit synthesiser words follow the divider bit, stored as written.
// - Clamp control register holds 100011 after reset.
// - Gain trim in bits 5..2: code 0 is +1.6 dB, 0.2 dB steps down.
// - Clamp bit one disables channel B clamp, bit zero channel A.
// - Two-bit reserved word nine resets to zero; host writes only zero.
// - Coarse offset control register resets to all zeros.
// - Coarse bit three recalibrates channel B, bit two channel A.
// - Coarse calibration is requested at start-up when the self calibration bit is high and runs once coarse bit zero is set.
// - Coarse bit one turns on the test pattern generator.
// - Coarse bit zero enables offset correction; host keeps it set during start-up.
// - Writing the low data word commits; host loads higher words first.
`timescale 1ns/100ps
`include "rfc_map.svh"
module rfc_regs
  import rfc_pkg::*;
(
  input  wire logic                   mclk_i,
  input  wire logic                   arst_n_i,
  input  wire logic                   port_wr_i,
  input  wire logic                   port_rd_i,
  input  wire logic [1:0]             port_sel_i,
  input  wire logic [7:0]             port_wdata_i,
  input  wire logic [`RFC_ADDR_W-1:0] int_addr_i,
  input  wire logic                   startup_self_cal_i,
  input  wire logic [1:0]             cal_done_i,
  output logic      [7:0]             port_rdata_o,
  output logic                        port_rdy_o,
  output rfc_ctrl_t                   ctrl_o,
  output rfc_synth_t                  synth_o,
  output logic      [1:0]             cal_go_o,
  output logic      [1:0]             cal_busy_o
);
  logic [5:0]             mid_hi_d;
  logic [5:0]             mid_hi_q;
  logic [7:0]             mid_d;
  logic [7:0]             mid_q;
  logic [`RFC_DATA_W-1:0] rd_hold_d;
  logic [`RFC_DATA_W-1:0] rd_hold_q;
  logic [7:0]             rdata_d;
  logic [7:0]             rdata_q;
  logic                   rdy_d;
  logic                   rdy_q;
  logic                   first_d;
  logic                   first_q;
  logic                   commit;
  logic                   low_rd;
  logic [`RFC_DATA_W-1:0] wword;
  logic [`RFC_DATA_W-1:0] rword;
  logic [`RFC_NUM_REGS-1:0] we;
  logic [1:0]             cal_req;
  logic                   coarse_on;

  logic                   clkdiv_q;
  logic [5:0]             clamp_q;
  logic [7:0]             rsvd6_q;
  logic [7:0]             rsvd7_q;
  logic [7:0]             rsvd8_q;
  logic [1:0]             rsvd9_q;
  logic [3:0]             coarse_q;
  logic [`RFC_DATA_W-1:0] synth_q [4];

  // The low data word access is the one that reaches the internal registers.
  assign commit = port_wr_i && (port_sel_i == `RFC_SEL_LOW);
  assign low_rd = port_rd_i && (port_sel_i == `RFC_SEL_LOW);
  assign wword  = {mid_hi_q, mid_q, port_wdata_i};

  always_comb begin
    we = '0;
    for (int i = 0; i < `RFC_NUM_REGS; i++) begin
      if (commit && (int_addr_i == 10'(i))) begin
        we[i] = 1'b1;
      end
    end
  end

  always_comb begin
    rword = '0;
    case (int_addr_i)
      `RFC_OFS_CLKDIV: rword = {21'h0, clkdiv_q};
      10'h001:         rword = synth_q[0];
      10'h002:         rword = synth_q[1];
      10'h003:         rword = synth_q[2];
      10'h004:         rword = synth_q[3];
      `RFC_OFS_CLAMP:  rword = {16'h0, clamp_q};
      `RFC_OFS_RSVD6:  rword = {14'h0, rsvd6_q};
      `RFC_OFS_RSVD7:  rword = {14'h0, rsvd7_q};
      `RFC_OFS_RSVD8:  rword = {14'h0, rsvd8_q};
      `RFC_OFS_RSVD9:  rword = {20'h0, rsvd9_q};
      `RFC_OFS_COARSE: rword = {18'h0, coarse_q};
      default:         rword = '0;
    endcase
  end

  // Higher data words are only held; reads of them come from the read hold.
  always_comb begin
    mid_hi_d  = mid_hi_q;
    mid_d     = mid_q;
    rd_hold_d = rd_hold_q;
    rdata_d   = rdata_q;
    rdy_d     = port_wr_i || port_rd_i;
    first_d   = 1'b0;
    if (port_wr_i) begin
      if (port_sel_i == `RFC_SEL_HIGH) begin
        mid_hi_d = port_wdata_i[5:0];
      end
      if (port_sel_i == `RFC_SEL_MID) begin
        mid_d = port_wdata_i;
      end
    end
    if (port_rd_i) begin
      case (port_sel_i)
        `RFC_SEL_LOW: begin
          rd_hold_d = rword;
          rdata_d   = rword[7:0];
        end
        `RFC_SEL_MID:  rdata_d = rd_hold_q[15:8];
        `RFC_SEL_HIGH: rdata_d = {2'h0, rd_hold_q[21:16]};
        default:       rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mid_hi_q  <= 6'h00;
      mid_q     <= 8'h00;
      rd_hold_q <= '0;
      rdata_q   <= 8'h00;
      rdy_q     <= 1'b0;
      first_q   <= 1'b1;
    end else begin
      mid_hi_q  <= mid_hi_d;
      mid_q     <= mid_d;
      rd_hold_q <= rd_hold_d;
      rdata_q   <= rdata_d;
      rdy_q     <= rdy_d;
      first_q   <= first_d;
    end
  end

  rfc_field_reg #(.W(1), .RST(`RFC_RST_CLKDIV)) u_clkdiv (
    .mclk_i   (mclk_i),
    .arst_n_i (arst_n_i),
    .we_i     (we[0]),
    .wdata_i  (wword),
    .q_o      (clkdiv_q)
  );

  for (genvar g = 0; g < 4; g++) begin : g_synth
    rfc_field_reg #(.W(`RFC_DATA_W), .RST(`RFC_RST_SYNTH)) u_word (
      .mclk_i   (mclk_i),
      .arst_n_i (arst_n_i),
      .we_i     (we[g+1]),
      .wdata_i  (wword),
      .q_o      (synth_q[g])
    );
  end

  rfc_field_reg #(.W(6), .RST(`RFC_RST_CLAMP)) u_clamp (
    .mclk_i   (mclk_i),
    .arst_n_i (arst_n_i),
    .we_i     (we[5]),
    .wdata_i  (wword),
    .q_o      (clamp_q)
  );

  // Reserved words are stored so that the host's mandated values read back.
  rfc_field_reg #(.W(8), .RST(`RFC_RST_RSVD)) u_rsvd6 (
    .mclk_i   (mclk_i),
    .arst_n_i (arst_n_i),
    .we_i     (we[6]),
    .wdata_i  (wword),
    .q_o      (rsvd6_q)
  );

  rfc_field_reg #(.W(8), .RST(`RFC_RST_RSVD)) u_rsvd7 (
    .mclk_i   (mclk_i),
    .arst_n_i (arst_n_i),
    .we_i     (we[7]),
    .wdata_i  (wword),
    .q_o      (rsvd7_q)
  );

  rfc_field_reg #(.W(8), .RST(`RFC_RST_RSVD)) u_rsvd8 (
    .mclk_i   (mclk_i),
    .arst_n_i (arst_n_i),
    .we_i     (we[8]),
    .wdata_i  (wword),
    .q_o      (rsvd8_q)
  );

  rfc_field_reg #(.W(2), .RST(`RFC_RST_RSVD9)) u_rsvd9 (
    .mclk_i   (mclk_i),
    .arst_n_i (arst_n_i),
    .we_i     (we[9]),
    .wdata_i  (wword),
    .q_o      (rsvd9_q)
  );

  rfc_field_reg #(.W(4), .RST(`RFC_RST_COARSE)) u_coarse (
    .mclk_i   (mclk_i),
    .arst_n_i (arst_n_i),
    .we_i     (we[10]),
    .wdata_i  (wword),
    .q_o      (coarse_q)
  );

  // A write with a calibrate bit set asks for a run; start-up asks once if enabled.
  assign cal_req[1] = (we[10] && wword[`RFC_BIT_CAL_B])
                      || (first_q && startup_self_cal_i);
  assign cal_req[0] = (we[10] && wword[`RFC_BIT_CAL_A])
                      || (first_q && startup_self_cal_i);

  // A write to the coarse register decides the enable for a request made in the same write.
  assign coarse_on = we[10] ? wword[`RFC_BIT_COARSE] : coarse_q[`RFC_BIT_COARSE];

  for (genvar c = 0; c < 2; c++) begin : g_cal
    rfc_cal_seq u_seq (
      .mclk_i   (mclk_i),
      .arst_n_i (arst_n_i),
      .req_i    (cal_req[c]),
      .enable_i (coarse_on),
      .done_i   (cal_done_i[c]),
      .go_o     (cal_go_o[c]),
      .busy_o   (cal_busy_o[c])
    );
  end

  always_comb begin
    ctrl_o.clk_div_two          = clkdiv_q;
    ctrl_o.gain_trim            = clamp_q[`RFC_TRIM_HI:`RFC_TRIM_LO];
    ctrl_o.clamp_dis_b          = clamp_q[`RFC_BIT_CLAMP_B];
    ctrl_o.clamp_dis_a          = clamp_q[`RFC_BIT_CLAMP_A];
    ctrl_o.cal_now_b            = coarse_q[`RFC_BIT_CAL_B];
    ctrl_o.cal_now_a            = coarse_q[`RFC_BIT_CAL_A];
    ctrl_o.test_pattern_gen_on  = coarse_q[`RFC_BIT_PN];
    ctrl_o.coarse_offset_fix_on = coarse_q[`RFC_BIT_COARSE];
    for (int k = 0; k < 4; k++) begin
      synth_o.word[k] = synth_q[k];
    end
  end

  assign port_rdata_o = rdata_q;
  assign port_rdy_o   = rdy_q;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  a_reset_values: assert property (
    first_q |-> (clkdiv_q == 1'b1) && (clamp_q == 6'h23)
  ) else $error("Divider or clamp register wrong after reset.");

  a_reset_zeros: assert property (
    first_q |-> (coarse_q == 4'h0) && (rsvd9_q == 2'h0)
  ) else $error("Coarse or reserved nine register not zero after reset.");

  a_synth_store: assert property (
    (commit && int_addr_i == 10'h003) |=> synth_o.word[2] == $past(wword)
  ) else $error("Synthesiser word two did not take the committed word.");

  a_narrow_store: assert property (
    (commit && int_addr_i == `RFC_OFS_CLAMP)
      |=> ctrl_o.gain_trim == $past(port_wdata_i[5:2])
          && ctrl_o.clamp_dis_a == $past(port_wdata_i[0])
  ) else $error("Clamp register did not keep the low bits.");

  a_mid_no_commit: assert property (
    (port_wr_i && port_sel_i != `RFC_SEL_LOW) |=> $stable(synth_o) && $stable(ctrl_o)
  ) else $error("A higher data word write changed a register.");

  a_div_follows: assert property (
    (commit && int_addr_i == `RFC_OFS_CLKDIV && port_wdata_i[0] == 1'b0)
      |=> ctrl_o.clk_div_two == 1'b0
  ) else $error("Divider bypass write not honoured.");

  a_pn_enable: assert property (
    (commit && int_addr_i == `RFC_OFS_COARSE)
      |=> ctrl_o.test_pattern_gen_on == $past(port_wdata_i[1])
  ) else $error("Test pattern enable does not follow the write.");

  a_cal_b_start: assert property (
    (we[10] && wword[3] && wword[0] && !cal_busy_o[1]) |-> ##[1:2] cal_go_o[1]
  ) else $error("Channel B recalibration did not start.");

  a_cal_gated: assert property (
    (cal_go_o != 2'b00) |-> coarse_q[`RFC_BIT_COARSE]
  ) else $error("Calibration started with correction disabled.");

  a_rdy_pulse: assert property (
    (port_wr_i || port_rd_i) |=> port_rdy_o
  ) else $error("Access not acknowledged on the next cycle.");

  a_read_order: assert property (
    low_rd |=> port_rdata_o == $past(rword[7:0]) && rd_hold_q == $past(rword)
  ) else $error("Low word read did not start the internal read.");

  a_rdy_idle: assert property (
    !(port_wr_i || port_rd_i) |=> !port_rdy_o
  ) else $error("Acknowledge raised without an access.");

  a_mid_load: assert property (
    (port_wr_i && port_sel_i == `RFC_SEL_MID) |=> mid_q == $past(port_wdata_i)
  ) else $error("Middle data word not held.");

  a_high_load: assert property (
    (port_wr_i && port_sel_i == `RFC_SEL_HIGH) |=> mid_hi_q == $past(port_wdata_i[5:0])
  ) else $error("High data word not held.");

  a_high_read: assert property (
    (port_rd_i && port_sel_i == `RFC_SEL_HIGH) |=> port_rdata_o[7:6] == 2'h0
  ) else $error("High data word read shows more than six bits.");

  a_clamp_b_map: assert property (
    (commit && int_addr_i == `RFC_OFS_CLAMP) |=> ctrl_o.clamp_dis_b == $past(port_wdata_i[1])
  ) else $error("Channel B clamp disable does not follow the write.");

  a_rsvd9_narrow: assert property (
    (commit && int_addr_i == `RFC_OFS_RSVD9) |=> rsvd9_q == $past(port_wdata_i[1:0])
  ) else $error("Reserved word nine did not keep its two low bits.");

  a_coarse_enable: assert property (
    (commit && int_addr_i == `RFC_OFS_COARSE)
      |=> ctrl_o.coarse_offset_fix_on == $past(port_wdata_i[0])
  ) else $error("Coarse correction enable does not follow the write.");

  a_cal_a_start: assert property (
    (we[10] && wword[2] && wword[0] && !cal_busy_o[0]) |-> ##1 cal_go_o[0]
  ) else $error("Channel A recalibration did not start.");

  a_synth_first: assert property (
    (commit && int_addr_i == `RFC_OFS_SYNTH0) |=> synth_o.word[0] == $past(wword)
  ) else $error("Synthesiser word zero did not take the committed word.");

  a_go_single: assert property (
    cal_go_o[1] |=> !cal_go_o[1]
  ) else $error("Channel B start pulse longer than one cycle.");

  a_high_addr_ignored: assert property (
    (commit && int_addr_i > `RFC_OFS_COARSE) |=> $stable(synth_o) && $stable(ctrl_o)
  ) else $error("A write above the register range changed a register.");
endmodule // rfc_regs

// ===== tb/rfc_host_model.sv
// Host processor model that drives the microport one data word at a time.
`timescale 1ns/100ps
`include "rfc_map.svh"
module rfc_host_model
  import rfc_pkg::*;
(
  input  wire logic                   mclk_i,
  input  wire logic                   rdy_i,
  input  wire logic [7:0]             rdata_i,
  output logic                        wr_o,
  output logic                        rd_o,
  output logic      [1:0]             sel_o,
  output logic      [7:0]             wdata_o,
  output logic      [`RFC_ADDR_W-1:0] addr_o
);
  int misses = 0;

  initial begin
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    sel_o   = 2'h0;
    wdata_o = 8'h00;
    addr_o  = '0;
  end

  // The low word goes last because it commits the whole word.
  task automatic write_reg(input logic [9:0] addr, input logic [21:0] data);
    @(posedge mclk_i);
    addr_o  <= addr;
    wr_o    <= 1'b1;
    sel_o   <= `RFC_SEL_HIGH;
    wdata_o <= {2'h0, data[21:16]};
    @(posedge mclk_i);
    sel_o   <= `RFC_SEL_MID;
    wdata_o <= data[15:8];
    @(posedge mclk_i);
    sel_o   <= `RFC_SEL_LOW;
    wdata_o <= data[7:0];
    @(posedge mclk_i);
    wr_o    <= 1'b0;
    wdata_o <= ~data[7:0];
  endtask

  task automatic read_byte(input logic [1:0] sel, output logic [7:0] b);
    int n;
    @(posedge mclk_i);
    rd_o  <= 1'b1;
    sel_o <= sel;
    @(posedge mclk_i);
    rd_o  <= 1'b0;
    for (n = 0; n < 4; n++) begin
      @(posedge mclk_i);
      if (rdy_i === 1'b1) break;
    end
    if (n == 4) misses++;
    b = rdata_i;
  endtask

  // The low word is read first since it latches the whole register.
  task automatic read_reg(input logic [9:0] addr, output logic [21:0] data);
    logic [7:0] lo, mi, hi;
    addr_o <= addr;
    read_byte(`RFC_SEL_LOW, lo);
    read_byte(`RFC_SEL_MID, mi);
    read_byte(`RFC_SEL_HIGH, hi);
    data = {hi[5:0], mi, lo};
  endtask
endmodule // rfc_host_model

// ===== tb/tb_rfc_regs.sv
// Self-checking testbench of the receiver front control bank.
`timescale 1ns/100ps
`include "rfc_map.svh"
module tb_rfc_regs;
  import rfc_pkg::*;
  typedef struct {logic [9:0] addr; logic [21:0] wdata; logic [21:0] rexp;} rfc_row_t;
  typedef struct {logic [3:0] data; int go_b; int go_a;} rfc_cal_row_t;

  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic startup_self_cal_i = 1'b1;
  logic [1:0] cal_done_i = 2'h0;
  logic port_wr_i, port_rd_i, port_rdy_o;
  logic [1:0] port_sel_i, cal_go_o, cal_busy_o;
  logic [7:0] port_wdata_i, port_rdata_o;
  logic [`RFC_ADDR_W-1:0] int_addr_i;
  rfc_ctrl_t ctrl_o;
  rfc_synth_t synth_o;
  int bad_count = 0;
  int tests_run = 0;
  int go_a = 0;
  int go_b = 0;
  logic [7:0] sel3_byte;
  rfc_row_t rows [0:11] = '{
    '{10'h000, 22'h000000, 22'h000000},
    '{10'h001, 22'h2abcde, 22'h2abcde},
    '{10'h002, 22'h3fffff, 22'h3fffff},
    '{10'h003, 22'h000001, 22'h000001},
    '{10'h004, 22'h155555, 22'h155555},
    '{10'h005, 22'h3fffbe, 22'h00003e},
    '{10'h006, 22'h000000, 22'h000000},
    '{10'h007, 22'h000000, 22'h000000},
    '{10'h008, 22'h000011, 22'h000011},
    '{10'h009, 22'h000000, 22'h000000},
    '{10'h00a, 22'h3ffff3, 22'h000003},
    '{10'h00b, 22'h155555, 22'h000000}};
  // Bit three is held back while bit zero is clear, then runs once it is set.
  rfc_cal_row_t cal_rows [0:4] = '{'{4'h9, 2, 1}, '{4'h5, 2, 2}, '{4'h8, 2, 2},
                                   '{4'h1, 3, 2}, '{4'h2, 3, 2}};

  always #2 mclk_i = ~mclk_i;

  rfc_host_model rfc_host_model_inst (
    .mclk_i (mclk_i), .rdy_i (port_rdy_o), .rdata_i (port_rdata_o), .wr_o (port_wr_i),
    .rd_o (port_rd_i), .sel_o (port_sel_i), .wdata_o (port_wdata_i), .addr_o (int_addr_i));

  rfc_regs rfc_regs_inst (
    .mclk_i (mclk_i), .arst_n_i (arst_n_i), .port_wr_i (port_wr_i), .port_rd_i (port_rd_i),
    .port_sel_i (port_sel_i), .port_wdata_i (port_wdata_i), .int_addr_i (int_addr_i),
    .startup_self_cal_i (startup_self_cal_i), .cal_done_i (cal_done_i),
    .port_rdata_o (port_rdata_o), .port_rdy_o (port_rdy_o), .ctrl_o (ctrl_o),
    .synth_o (synth_o), .cal_go_o (cal_go_o), .cal_busy_o (cal_busy_o));

  // The calibration engine answers one cycle after it sees a busy channel.
  always @(posedge mclk_i) begin
    cal_done_i <= cal_busy_o & ~cal_done_i;
    if (cal_go_o[1] === 1'b1) go_b++;
    if (cal_go_o[0] === 1'b1) go_a++;
  end

  task automatic chk(input string what, input logic [87:0] seen, input logic [87:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rd_chk(input logic [9:0] addr, input logic [21:0] exp);
    logic [21:0] got;
    rfc_host_model_inst.read_reg(addr, got);
    chk("readback", 88'(got), 88'(exp));
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge mclk_i);
    bad_count++;
    final_report();
  end

  initial begin
    repeat (8) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    @(posedge mclk_i);
    chk("ctrl_reset", 88'(ctrl_o), 88'({1'h1, 6'h23, 4'h0}));
    chk("synth_reset", synth_o, 88'h0);
    rd_chk(10'h000, 22'h000001);
    rd_chk(10'h005, 22'h000023);
    rd_chk(10'h009, 22'h000000);
    rd_chk(10'h00a, 22'h000000);
    chk("cal_held", 88'({go_b, go_a}), 88'({32'd0, 32'd0}));
    foreach (rows[i]) begin
      rfc_host_model_inst.write_reg(rows[i].addr, rows[i].wdata);
      rd_chk(rows[i].addr, rows[i].rexp);
    end
    chk("ctrl_fields", 88'(ctrl_o), 88'({1'h0, 6'h3e, 4'h3}));
    chk("synth_words", synth_o,
        {22'h155555, 22'h000001, 22'h3fffff, 22'h2abcde});
    chk("startup_cal", 88'({go_b, go_a}), 88'({32'd1, 32'd1}));
    foreach (cal_rows[i]) begin
      rfc_host_model_inst.write_reg(10'h00a, {18'h0, cal_rows[i].data});
      rd_chk(10'h00a, {18'h0, cal_rows[i].data});
      chk("coarse_bits", 88'(ctrl_o[3:0]), 88'(cal_rows[i].data));
      chk("cal_runs", 88'({go_b, go_a}), 88'({cal_rows[i].go_b, cal_rows[i].go_a}));
    end
    startup_self_cal_i <= 1'b0;
    arst_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    chk("ctrl_rereset", 88'(ctrl_o), 88'({1'h1, 6'h23, 4'h0}));
    chk("synth_rereset", synth_o, 88'h0);
    chk("cal_rereset", 88'({cal_go_o, cal_busy_o}), 88'h0);
    arst_n_i <= 1'b1;
    rd_chk(10'h005, 22'h000023);
    rfc_host_model_inst.write_reg(10'h00a, 22'h000001);
    rd_chk(10'h00a, 22'h000001);
    chk("no_startup_cal", 88'({go_b, go_a}), 88'({32'd3, 32'd2}));
    rfc_host_model_inst.read_byte(2'h3, sel3_byte);
    chk("sel3_read", 88'(sel3_byte), 88'h0);
    chk("host_waits", 88'(rfc_host_model_inst.misses), 88'h0);
    final_report();
  end
endmodule // tb_rfc_regs
